/* File: watchdog_control_kick_count.sv */
// Contract
// R1 - Control bits 4..2 enable stall lines 2..0; read/write, reset 0.
// R2 - Hardware sets underflow flag, control bit 1, on underflow; resets 0.
// R3 - Writing one clears underflow flag; writing zero leaves it unchanged.
// R4 - Control bit 0 enables watchdog; resets to 0, inactive by default.
// R5 - Kick register is a storage-free strobe; reads return zero.
// R6 - Kick write while enabled reloads counter from load value.
// R7 - Kick write while disabled changes nothing.
// R8 - Count register shows live 16-bit counter, read-only, reset 0xf.
// R9 - Underflow before reload emits event pulse and sets underflow flag.
// R10 - Enabled counter decrements once per 33 tick clock cycles.
// R11 - Writing load register also reloads the counter with the new value.
// R12 - Enabled stall line asserted holds the counter.
// R13 - Control bits 7..5 read zero and ignore writes.
`include "wdt_ctl_regs.svh"
`default_nettype none
module watchdog_control_kick_count #(
	parameter int TICKS_PER_STEP = `WDT_TICKS_PER_STEP
) (
	input  wire logic                  core_clk_in,          // 40 MHz clock
	input  wire logic                  srst_in,              // Sync reset
	input  wire wdt_ctl_pkg::reg_req_t reg_req_in,           // Register port
	input  wire logic                  watchdog_tick_clock_in, // Slow tick
	input  wire logic [2:0]            stall_request_in,     // Stall lines
	output logic [15:0]                reg_rdata_out,        // Read data
	output logic                       watchdog_event_out    // Expiry pulse
);

	localparam int PW = $clog2(TICKS_PER_STEP);

	logic [15:0]   load_value;
	logic [15:0]   count;
	logic [2:0]    stall_input_enable;
	logic          underflow_reset_flag;
	logic          enable;
	logic [PW-1:0] prescale;
	logic          tick_prev;

	function automatic logic hit(input wdt_ctl_pkg::reg_req_t r,
		input logic [7:0] ofs);
		hit = r.addr == ofs;
	endfunction : hit

	// Decode
	wire wr_load = reg_req_in.wr && hit(reg_req_in, `WDT_OFS_LOAD);
	wire wr_ctl  = reg_req_in.wr && hit(reg_req_in, `WDT_OFS_CONTROL);
	wire wr_kick = reg_req_in.wr && hit(reg_req_in, `WDT_OFS_KICK);
	wire kick_ok = wr_kick && enable;                         // [R6] [R7]
	wire reload  = wr_load || kick_ok;                        // [R11]

	// Tick input is synchronous; its rising edge paces the prescaler.
	// Ticks narrower than one core clock would be missed, so the tick
	// source must hold each level for at least one core cycle.
	wire tick_rise = watchdog_tick_clock_in && !tick_prev;
	wire stalled   = |(stall_input_enable & stall_request_in); // [R1] [R12]
	wire run       = enable && !stalled && tick_rise;         // [R4] [R12]
	wire last_tick = prescale == PW'(TICKS_PER_STEP - 1);
	wire step      = run && last_tick;                        // [R10]
	wire underflow = step && count == 16'h0000;               // [R9]

	wire [15:0] reload_src = wr_load ? reg_req_in.wdata : load_value;
	wire [15:0] next_count = reload ? reload_src :
		underflow ? load_value :
		step ? count - 16'h0001 : count;
	wire [PW-1:0] next_prescale = reload ? '0 :
		!run ? prescale :
		last_tick ? '0 : prescale + PW'(1);

	// Set wins over a same-cycle clear so an underflow is never lost;
	// firmware that clears in that very cycle sees the flag again and
	// must read it once more before trusting it is gone
	wire clr_flag = wr_ctl && reg_req_in.wdata[`WDT_BIT_UFLOW];  // [R3]
	wire next_flag = underflow || (underflow_reset_flag && !clr_flag); // [R2]

	wire [7:0] ctl_view = {3'b000, stall_input_enable,        // [R13]
		underflow_reset_flag, enable};
	wire [15:0] next_rdata =
		!reg_req_in.rd ? 16'h0000 :
		hit(reg_req_in, `WDT_OFS_COUNT) ? count :            // [R8]
		hit(reg_req_in, `WDT_OFS_CONTROL) ? {8'h00, ctl_view} :
		16'h0000;                                            // [R5]

	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			load_value <= `WDT_LOAD_RESET;
			count      <= `WDT_COUNT_RESET;                      // [R8]
			prescale   <= '0;
			tick_prev  <= 1'b0;
		end else begin
			if (wr_load)
				load_value <= reg_req_in.wdata;
			count     <= next_count;
			prescale  <= next_prescale;
			tick_prev <= watchdog_tick_clock_in;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			stall_input_enable   <= 3'b000;                    // [R1]
			underflow_reset_flag <= 1'b0;                      // [R2]
			enable               <= 1'b0;                      // [R4]
			watchdog_event_out   <= 1'b0;
			reg_rdata_out        <= 16'h0000;
		end else begin
			if (wr_ctl) begin
				stall_input_enable <= reg_req_in.wdata[
					`WDT_BIT_STALL_HI:`WDT_BIT_STALL_LO];           // [R1]
				enable <= reg_req_in.wdata[`WDT_BIT_ENABLE];     // [R4]
			end
			underflow_reset_flag <= next_flag;
			watchdog_event_out   <= underflow;                 // [R9]
			reg_rdata_out        <= next_rdata;
		end
	end

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (srst_in);

	sequence s_kick_enabled;
		wr_kick && enable && !wr_load;
	endsequence
	sequence s_idle_bus;
		!reg_req_in.wr;
	endsequence

	a_kick_reload: assert property (s_kick_enabled |=>              // [R6]
		count == load_value)
		else $error("kick did not reload counter");
	a_kick_ignored: assert property (wr_kick && !enable |=>         // [R7]
		$stable(count) && $stable(load_value) && $stable(prescale))
		else $error("kick while disabled changed state");
	a_load_reload: assert property (wr_load |=>                     // [R11]
		count == $past(reg_req_in.wdata) && load_value == count)
		else $error("load write did not reload counter");
	a_flag_clear: assert property (underflow_reset_flag && clr_flag // [R3]
		&& !underflow |=> !underflow_reset_flag)
		else $error("write one did not clear flag");
	a_flag_keep: assert property (underflow_reset_flag && wr_ctl && // [R3]
		!reg_req_in.wdata[`WDT_BIT_UFLOW] |=> underflow_reset_flag)
		else $error("write zero changed flag");
	a_event_cause: assert property (enable && !stalled && tick_rise // [R9]
		&& last_tick && count == 16'h0000 && !reload
		|=> watchdog_event_out && underflow_reset_flag
		##1 !watchdog_event_out)
		else $error("underflow did not pulse event and set flag");
	a_stall_hold: assert property (s_idle_bus and enable && stalled // [R12]
		|=> $stable(count))
		else $error("counter moved while stalled");
	a_step_rate: assert property (s_idle_bus and enable && !stalled // [R10]
		&& tick_rise && !last_tick |=> $stable(count))
		else $error("counter stepped before 33 ticks");
	a_disabled_hold: assert property (s_idle_bus and !enable        // [R4]
		|=> $stable(count) && !watchdog_event_out)
		else $error("counter moved while disabled");
	a_kick_read_zero: assert property (reg_req_in.rd &&             // [R5]
		hit(reg_req_in, `WDT_OFS_KICK) |=> reg_rdata_out == 16'h0000)
		else $error("kick read not zero");
	a_reserved_zero: assert property (reg_req_in.rd &&              // [R13]
		hit(reg_req_in, `WDT_OFS_CONTROL) |=> reg_rdata_out[15:5] == '0)
		else $error("reserved control bits not zero");
	a_count_read: assert property (reg_req_in.rd &&                 // [R8]
		hit(reg_req_in, `WDT_OFS_COUNT) |=> reg_rdata_out == $past(count))
		else $error("count read wrong");

	// Underflow has three effects, all seen next cycle: counter reload, flag set and a one-cycle pulse
	sequence s_underflow;
		underflow && !reload;
	endsequence
	sequence s_event_pulse;
		watchdog_event_out ##1 !watchdog_event_out;
	endsequence

	// Event output and sticky flag
	a_event_width: assert property (watchdog_event_out |->          // [R9]
		s_event_pulse)
		else $error("event pulse wider than one cycle");
	a_event_source: assert property (!underflow |=>                 // [R9]
		!watchdog_event_out)
		else $error("event without underflow");
	a_uflow_reload: assert property (s_underflow |=>                // [R9]
		count == load_value)
		else $error("underflow did not reload counter");
	a_flag_set: assert property (underflow |=>                      // [R2]
		underflow_reset_flag)
		else $error("underflow did not set flag");
	a_flag_no_set: assert property (!underflow_reset_flag &&        // [R2]
		!underflow |=> !underflow_reset_flag)
		else $error("flag set without underflow");

	// Control register storage
	a_ctl_write: assert property (wr_ctl |=>                        // [R1]
		stall_input_enable == $past(reg_req_in.wdata[4:2]) &&
		enable == $past(reg_req_in.wdata[0]))
		else $error("control write not stored");
	a_ctl_hold: assert property (!wr_ctl |=>                        // [R4]
		$stable(stall_input_enable) && $stable(enable))
		else $error("control changed without write");
	a_ctl_read: assert property (reg_req_in.rd &&                   // [R1]
		hit(reg_req_in, `WDT_OFS_CONTROL) |=>
		reg_rdata_out[4:0] == $past(ctl_view[4:0]))
		else $error("control read wrong");

	// Counter and prescaler pacing
	a_step_dec: assert property (step && !reload &&                 // [R10]
		count != 16'h0000 |=> count == $past(count) - 16'h0001)
		else $error("counter did not decrement by one");
	a_prescale_range: assert property (prescale <=                  // [R10]
		PW'(TICKS_PER_STEP - 1))
		else $error("prescaler out of range");
	a_prescale_stall: assert property (s_idle_bus and enable &&     // [R12]
		stalled |=> $stable(prescale))
		else $error("prescaler moved while stalled");
	a_prescale_off: assert property (s_idle_bus and !enable |=>     // [R4]
		$stable(prescale))
		else $error("prescaler moved while disabled");
	a_kick_prescale: assert property (s_kick_enabled |=>            // [R6]
		prescale == '0)
		else $error("kick did not restart prescaler");
	a_load_hold: assert property (!wr_load |=>                      // [R11]
		$stable(load_value))
		else $error("load value changed without write");
	a_read_idle: assert property (!reg_req_in.rd |=>                // [R5]
		reg_rdata_out == 16'h0000)
		else $error("read data not zero when idle");

endmodule : watchdog_control_kick_count
`default_nettype wire

/* File: wdt_ctl_regs.svh */
`ifndef WDT_CTL_REGS_SVH
`define WDT_CTL_REGS_SVH

// Byte offsets on the internal register port
`define WDT_OFS_COUNT      8'h00
`define WDT_OFS_LOAD       8'h00
`define WDT_OFS_CONTROL    8'h04
`define WDT_OFS_KICK       8'h08

// Control register fields
`define WDT_BIT_ENABLE     0
`define WDT_BIT_UFLOW      1
`define WDT_BIT_STALL_LO   2
`define WDT_BIT_STALL_HI   4

// Reset values and timing
`define WDT_LOAD_RESET     16'h000f
`define WDT_COUNT_RESET    16'h000f
`define WDT_CTL_RESET      8'h00
`define WDT_TICKS_PER_STEP 33

`endif

/* File: wdt_ctl_pkg.sv */
`default_nettype none
package wdt_ctl_pkg;
	// One register port request, sampled every clock
	typedef struct packed {
		logic        wr;    // Write strobe, one cycle
		logic        rd;    // Read strobe, one cycle
		logic [7:0]  addr;  // Byte offset
		logic [15:0] wdata; // Write data, narrow registers use low bits
	} reg_req_t;
endpackage : wdt_ctl_pkg
`default_nettype wire

/* File: watchdog_control_kick_count_tb_top.sv */
`include "wdt_ctl_regs.svh"
`default_nettype none
module watchdog_control_kick_count_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic                  clk;
	logic                  srst;
	wdt_ctl_pkg::reg_req_t req = '0;
	logic                  tick = 1'b0;
	logic [2:0]            stall = 3'h0;
	logic [15:0]           rdata;
	logic                  evt;
	int                    n_mismatch = 0;
	int                    checks = 0;
	int                    n_events = 0;

	watchdog_control_kick_count #(.TICKS_PER_STEP(2))
	u_watchdog_control_kick_count (
		.core_clk_in           (clk),
		.srst_in               (srst),
		.reg_req_in            (req),
		.watchdog_tick_clock_in(tick),
		.stall_request_in      (stall),
		.reg_rdata_out         (rdata),
		.watchdog_event_out    (evt)
	);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk) if (evt === 1'b1) n_events++;

	task automatic report_and_stop;
		if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
			n_mismatch++;
		end
	endtask : chk

	// Strobes last one cycle; the next access starts a full cycle later
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk) req = '{1'b1, 1'b0, a, d};
		@(negedge clk) req = '0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(negedge clk) req = '{1'b0, 1'b1, a, 16'h0000};
		@(negedge clk) req = '0;
		chk(rdata, exp);
	endtask : rd

	task automatic ticks(input int n);
		repeat (n) begin
			@(negedge clk) tick = 1'b1;
			@(negedge clk) tick = 1'b0;
		end
	endtask : ticks

	task automatic do_reset;
		srst = 1'b1;
		repeat (20) @(negedge clk);
		srst = 1'b0;
	endtask : do_reset

	task automatic t_reset;
		rd(`WDT_OFS_COUNT, `WDT_COUNT_RESET);
		rd(`WDT_OFS_CONTROL, 16'h0000);
		rd(`WDT_OFS_KICK, 16'h0000);
		rd(8'h0c, 16'h0000);
	endtask : t_reset

	task automatic t_count;
		wr(`WDT_OFS_LOAD, 16'h0005);
		rd(`WDT_OFS_COUNT, 16'h0005);
		ticks(4);
		rd(`WDT_OFS_COUNT, 16'h0005);
		wr(`WDT_OFS_CONTROL, 16'h0001);
		ticks(2);
		rd(`WDT_OFS_COUNT, 16'h0004);
		wr(`WDT_OFS_CONTROL, 16'h0000);
		wr(`WDT_OFS_KICK, 16'h00ff);
		rd(`WDT_OFS_COUNT, 16'h0004);
		wr(`WDT_OFS_CONTROL, 16'h0001);
		wr(`WDT_OFS_KICK, 16'h0000);
		rd(`WDT_OFS_COUNT, 16'h0005);
		rd(`WDT_OFS_KICK, 16'h0000);
	endtask : t_count

	task automatic t_stall;
		wr(`WDT_OFS_CONTROL, 16'h00ff);
		rd(`WDT_OFS_CONTROL, 16'h001d);
		for (int i = 0; i < 3; i++) begin
			stall = 3'h1 << i;
			ticks(2);
			stall = 3'h0;
			rd(`WDT_OFS_COUNT, 16'h0005);
		end
		// Stall lines without their enable bits must not freeze the count
		wr(`WDT_OFS_CONTROL, 16'h0001);
		stall = 3'h7;
		ticks(2);
		stall = 3'h0;
		rd(`WDT_OFS_COUNT, 16'h0004);
	endtask : t_stall

	task automatic t_uflow;
		wr(`WDT_OFS_LOAD, 16'h0001);
		ticks(2);
		n_events = 0;
		ticks(2);
		repeat (3) @(negedge clk);
		chk(n_events[15:0], 16'h0001);
		rd(`WDT_OFS_COUNT, 16'h0001);
		rd(`WDT_OFS_CONTROL, 16'h0003);
		wr(`WDT_OFS_CONTROL, 16'h0001);
		rd(`WDT_OFS_CONTROL, 16'h0003);
		wr(`WDT_OFS_CONTROL, 16'h0003);
		rd(`WDT_OFS_CONTROL, 16'h0001);
		// Leave state dirty so the mid-run reset has work to undo
		wr(`WDT_OFS_CONTROL, 16'h001d);
		wr(`WDT_OFS_LOAD, 16'h0033);
	endtask : t_uflow

	task automatic t_load_default;
		wr(`WDT_OFS_CONTROL, 16'h0001);
		wr(`WDT_OFS_KICK, 16'h0000);
		rd(`WDT_OFS_COUNT, `WDT_LOAD_RESET);
	endtask : t_load_default

	initial begin
		do_reset();
		t_reset();
		t_count();
		t_stall();
		t_uflow();
		// A second reset in mid-run must restore every default
		do_reset();
		t_reset();
		t_load_default();
		report_and_stop();
	end

	initial begin
		#100000;
		n_mismatch++;
		report_and_stop();
	end
endmodule : watchdog_control_kick_count_tb_top
`default_nettype wire
